// *** common/pcstack_pkg.sv ***
/*
 * shared constants and carriers for the program counter, return stack
 * and indirect addressing block.
 * assumes a single core clock and one command per clock from the
 * instruction execution and interrupt logic.
 */
package pcstack_pkg;

    // widths
    localparam int PC_W = 13;
    localparam int LOW_W = 8;
    localparam int HIGH_W = 5;
    localparam int JUMP_W = 11;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int FADDR_W = 7;
    localparam int EADDR_W = 9;

    // reset values
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [HIGH_W-1:0] LATCH_RESET = 5'h00;
    localparam logic [LOW_W-1:0] FP_RESET = 8'h00;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;

    // interrupt vector address
    localparam logic [PC_W-1:0] INTR_VECTOR = 13'h0004;

    // file address of the indirect data port in every bank
    localparam logic [FADDR_W-1:0] INDIRECT_PORT_ADDR = 7'h00;
    // value returned when the indirect port reads itself
    localparam logic [LOW_W-1:0] SELF_READ_VALUE = 8'h00;

    // field positions inside the high latch
    localparam int LATCH_PAGE_LSB = 3;
    localparam int LATCH_PAGE_MSB = 4;

    // program counter commands, gray coded along step -> write -> jump paths
    typedef enum logic [2:0] {
        PC_HOLD = 3'b000,
        PC_STEP = 3'b001,
        PC_WRITE_LOW = 3'b011,
        PC_GOTO = 3'b010,
        PC_CALL = 3'b110,
        PC_INTR = 3'b111,
        PC_RETURN = 3'b101
    } pc_op_e;

    typedef struct packed {
        pc_op_e op;
        logic [LOW_W-1:0] low_data;
        logic [JUMP_W-1:0] jump_addr;
    } pc_cmd_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] bank;
        logic [FADDR_W-1:0] addr;
    } data_req_s;

    typedef struct packed {
        logic valid;
        logic [EADDR_W-1:0] eff_addr;
        logic wr_en;
        logic rd_zero;
        logic indirect;
    } data_acc_s;

endpackage

// *** rtl/return_stack.sv ***
/*
 * eight entry circular return-address stack built from flip-flops.
 * assumes at most one of push and pop per clock; pushing beyond eight
 * entries or popping an empty stack wraps silently.
 */
`timescale 1ns/10ps

module return_stack
    import pcstack_pkg::*;
(
    input wire logic clock_i, // core clock
    input wire logic nrst_i, // async reset, active low
    input wire logic push_i, // store push_data_i
    input wire logic pop_i, // drop most recent entry
    input wire logic [PC_W-1:0] push_data_i, // address to store
    output logic [PC_W-1:0] top_o // most recently pushed entry
);

    logic [PC_W-1:0] mem_q [STACK_DEPTH];
    logic [PC_W-1:0] mem_d [STACK_DEPTH];
    logic [SP_W-1:0] sp_q; // next free slot, never visible to software
    logic [SP_W-1:0] sp_d;
    logic [SP_W-1:0] top_idx;

    // index of the most recent entry; wraps from 0 to 7
    assign top_idx = sp_q - 3'h1;
    assign top_o = mem_q[top_idx];

    // next pointer and storage
    always_comb begin
        mem_d = mem_q;
        sp_d = sp_q;
        if (push_i) begin
            mem_d[sp_q] = push_data_i;
            sp_d = sp_q + 3'h1;
        end else if (pop_i) begin
            sp_d = top_idx;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sp_q <= SP_RESET;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                mem_q[i] <= PC_RESET;
            end
        end else begin
            sp_q <= sp_d;
            mem_q <= mem_d;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    wrap_push_a: assert property (push_i |=> sp_q == $past(sp_q) + 3'h1)
        else $error("stack pointer did not advance on push");
    pop_top_a: assert property (push_i ##1 pop_i |-> top_o == $past(push_data_i))
        else $error("pop did not offer the last pushed address");

endmodule

// *** rtl/pc_addr_unit.sv ***
/*
 * program counter, high-address latch, return stack and indirect data
 * addressing of a small 8-bit core.
 * assumes the execution and interrupt logic issues one pc command per
 * clock on the core clock, and that pc_o already points at the
 * instruction to return to when a call or interrupt is issued.
 */
`timescale 1ns/10ps

module pc_addr_unit
    import pcstack_pkg::*;
(
    input wire logic clock_i, // core clock, 125 MHz
    input wire logic nrst_i, // any reset, async, active low
    input wire pc_cmd_s pc_cmd_i, // program counter command
    input wire logic latch_we_i, // write high latch
    input wire logic [HIGH_W-1:0] latch_wdata_i, // high latch data
    input wire logic fp_we_i, // write file pointer
    input wire logic [LOW_W-1:0] fp_wdata_i, // file pointer data
    input wire logic indirect_bank_bit_i, // bank bit of status register
    input wire data_req_s data_req_i, // data memory access request
    output logic [PC_W-1:0] pc_o, // program counter
    output logic [LOW_W-1:0] pc_low_byte_reg_o, // readable low byte
    output logic [HIGH_W-1:0] pc_high_latch_o, // readable high latch
    output logic [LOW_W-1:0] file_pointer_reg_o, // readable file pointer
    output data_acc_s data_acc_o // resolved data access
);

    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [HIGH_W-1:0] latch_q;
    logic [HIGH_W-1:0] latch_d;
    logic [LOW_W-1:0] fp_q;
    logic [LOW_W-1:0] fp_d;
    data_acc_s acc_q;
    data_acc_s acc_d;
    logic push;
    logic pop;
    logic [PC_W-1:0] stack_top;

    // joins a latch field and a lower part into a full counter value
    function automatic logic [PC_W-1:0] join_pc(input logic [HIGH_W-1:0] upper,
                                                 input logic [LOW_W-1:0] lower);
        return {upper, lower};
    endfunction

    // true when a file address names the indirect data port
    function automatic logic is_port(input logic [FADDR_W-1:0] addr);
        return addr == INDIRECT_PORT_ADDR;
    endfunction

    // push on call or interrupt vectoring
    assign push = (pc_cmd_i.op == PC_CALL) || (pc_cmd_i.op == PC_INTR);
    // the single return command pops
    assign pop = pc_cmd_i.op == PC_RETURN;

    // pointer lives only inside the stack, no port reaches it
    return_stack u_stack (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .push_i(push),
        .pop_i(pop),
        .push_data_i(pc_q),
        .top_o(stack_top)
    );

    // next program counter
    always_comb begin
        pc_d = pc_q;
        case (pc_cmd_i.op)
            PC_HOLD: pc_d = pc_q;
            PC_STEP: pc_d = pc_q + 13'h0001;
            // all thirteen bits change at once
            PC_WRITE_LOW: pc_d = join_pc(latch_q, pc_cmd_i.low_data);
            // page bits from latch 4..3, for the rest
            PC_GOTO, PC_CALL: pc_d = {latch_q[LATCH_PAGE_MSB:LATCH_PAGE_LSB],
                                      pc_cmd_i.jump_addr};
            PC_INTR: pc_d = INTR_VECTOR;
            PC_RETURN: pc_d = stack_top;
            default: pc_d = pc_q;
        endcase
    end

    // next latch and pointer values
    always_comb begin
        // only an explicit latch write changes the latch
        latch_d = latch_we_i ? latch_wdata_i : latch_q;
        fp_d = fp_we_i ? fp_wdata_i : fp_q;
    end

    // resolve a data access, one cycle after the request
    always_comb begin
        acc_d.valid = data_req_i.valid;
        acc_d.indirect = is_port(data_req_i.addr);
        acc_d.rd_zero = 1'b0;
        acc_d.wr_en = data_req_i.valid && data_req_i.write;
        acc_d.eff_addr = {data_req_i.bank, data_req_i.addr};
        if (acc_d.indirect) begin
            // access goes to the pointed location
            // bank bit joined to the eight bit pointer
            acc_d.eff_addr = {indirect_bank_bit_i, fp_q};
            if (is_port(fp_q[FADDR_W-1:0])) begin
                // self access reads zero and writes nothing
                acc_d.rd_zero = data_req_i.valid && !data_req_i.write;
                acc_d.wr_en = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pc_q <= PC_RESET;
            latch_q <= LATCH_RESET;
            fp_q <= FP_RESET;
            acc_q <= '0;
        end else begin
            pc_q <= pc_d;
            latch_q <= latch_d;
            fp_q <= fp_d;
            acc_q <= acc_d;
        end
    end

    // low byte visible, upper bits only as part of pc_o
    assign pc_o = pc_q;
    assign pc_low_byte_reg_o = pc_q[LOW_W-1:0];
    assign pc_high_latch_o = latch_q;
    assign file_pointer_reg_o = fp_q;
    assign data_acc_o = acc_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    low_write_a: assert property (
        pc_cmd_i.op == PC_WRITE_LOW |=>
            pc_o == {$past(latch_q), $past(pc_cmd_i.low_data)})
        else $error("low byte write did not load latch into upper bits");
    jump_page_a: assert property (
        (pc_cmd_i.op == PC_GOTO || pc_cmd_i.op == PC_CALL) |=>
            pc_o[12:11] == $past(latch_q[4:3]))
        else $error("jump page bits not taken from latch bits 4..3");
    jump_field_a: assert property (
        pc_cmd_i.op == PC_GOTO |=> pc_o[10:0] == $past(pc_cmd_i.jump_addr))
        else $error("jump low bits not taken from instruction field");
    call_return_a: assert property (
        pc_cmd_i.op == PC_CALL ##1 pc_cmd_i.op == PC_RETURN |=>
            pc_o == $past(pc_o, 2))
        else $error("return did not come back to the calling address");
    intr_return_a: assert property (
        pc_cmd_i.op == PC_INTR ##1 pc_cmd_i.op == PC_STEP
            ##1 pc_cmd_i.op == PC_RETURN |=> pc_o == $past(pc_o, 3))
        else $error("return from interrupt lost the pushed address");
    latch_hold_a: assert property (
        (push || pop) && !latch_we_i |=> $stable(latch_q))
        else $error("stack operation disturbed the high latch");
    self_read_a: assert property (
        data_req_i.valid && is_port(data_req_i.addr) && is_port(fp_q[6:0])
            |=> !data_acc_o.wr_en && data_acc_o.rd_zero == !$past(data_req_i.write))
        else $error("self indirect access not suppressed");
    indirect_addr_a: assert property (
        data_req_i.valid && is_port(data_req_i.addr) |=>
            data_acc_o.eff_addr == {$past(indirect_bank_bit_i), $past(fp_q)})
        else $error("indirect address not bank bit joined to pointer");
    step_count_a: assert property (
        pc_cmd_i.op == PC_STEP |=> pc_o == $past(pc_o) + 13'h0001)
        else $error("counter did not advance by one");

    // further counter checks
    call_field_a: assert property (
        pc_cmd_i.op == PC_CALL |=> pc_o[10:0] == $past(pc_cmd_i.jump_addr))
        else $error("call low bits not taken from instruction field");
    intr_vector_a: assert property (
        pc_cmd_i.op == PC_INTR |=> pc_o == INTR_VECTOR)
        else $error("interrupt did not branch to its vector");
    hold_pc_a: assert property (
        pc_cmd_i.op == PC_HOLD |=> $stable(pc_o))
        else $error("counter moved without a command");
    return_pop_a: assert property (
        pc_cmd_i.op == PC_RETURN |=> pc_o == $past(stack_top))
        else $error("return did not load the stack top");

    // latch and pointer write checks
    latch_write_a: assert property (
        latch_we_i |=> pc_high_latch_o == $past(latch_wdata_i))
        else $error("high latch did not take the written value");
    pointer_write_a: assert property (
        fp_we_i |=> file_pointer_reg_o == $past(fp_wdata_i))
        else $error("file pointer did not take the written value");

    // direct accesses bypass the pointer
    direct_addr_a: assert property (
        data_req_i.valid && !is_port(data_req_i.addr) |=>
            !data_acc_o.indirect
            && data_acc_o.eff_addr == {$past(data_req_i.bank), $past(data_req_i.addr)})
        else $error("direct access address not bank joined to file address");
    direct_write_a: assert property (
        data_req_i.valid && !is_port(data_req_i.addr) |=>
            data_acc_o.wr_en == $past(data_req_i.write) && !data_acc_o.rd_zero)
        else $error("direct access strobes altered");

endmodule

// *** testbench/exec_model.sv ***
/* execution and interrupt logic model: issues one command per clock.
   assumes each task is entered just after a rising edge. */
`timescale 1ns/10ps

module exec_model
    import pcstack_pkg::*;
(
    input wire logic clock_i, // core clock
    input wire logic [PC_W-1:0] pc_i, // current counter
    input wire logic [HIGH_W-1:0] latch_i, // current high latch
    output pc_cmd_s pc_cmd_o, // counter command
    output logic latch_we_o, // latch write
    output logic [HIGH_W-1:0] latch_wdata_o, // latch data
    output logic fp_we_o, // pointer write
    output logic [LOW_W-1:0] fp_wdata_o, // pointer data
    output logic bank_bit_o, // indirect bank bit
    output data_req_s data_req_o // data request
);
    // strobes low, command hold
    task automatic idle();
        pc_cmd_o = '0;
        latch_we_o = 1'b0;
        fp_we_o = 1'b0;
        data_req_o = '0;
    endtask

    // one command taken at the next edge, idle after it when last
    task automatic op(input pc_op_e o, input logic [LOW_W-1:0] lo,
                      input logic [JUMP_W-1:0] j, input bit last);
        pc_cmd_o = '{op: o, low_data: lo, jump_addr: j};
        @(posedge clock_i);
        #1;
        if (last) begin
            idle();
        end
    endtask

    // one latch write
    task automatic latch(input logic [HIGH_W-1:0] v);
        latch_we_o = 1'b1;
        latch_wdata_o = v;
        @(posedge clock_i);
        #1;
        latch_we_o = 1'b0;
    endtask

    // one pointer write
    task automatic fp(input logic [LOW_W-1:0] v);
        fp_we_o = 1'b1;
        fp_wdata_o = v;
        @(posedge clock_i);
        #1;
        fp_we_o = 1'b0;
    endtask

    // one data request; it stands until the next request or idle
    task automatic req(input logic w, input logic [1:0] b, input logic [FADDR_W-1:0] a,
                       input logic ib);
        bank_bit_o = ib;
        data_req_o = '{valid: 1'b1, write: w, bank: b, addr: a};
        @(posedge clock_i);
        #1;
    endtask

    // computed jump: add offset to the low byte
    task automatic jump_table(input logic [LOW_W-1:0] ofs);
        logic [LOW_W:0] sum;
        sum = {1'b0, pc_i[LOW_W-1:0]} + {1'b0, ofs};
        if (sum[LOW_W]) begin
            latch(latch_i + 5'h01);
        end
        op(PC_WRITE_LOW, sum[LOW_W-1:0], '0, 1'b1);
    endtask

    // idle at time zero
    initial begin
        bank_bit_o = 1'b0;
        idle();
    end
endmodule

// *** testbench/test_pc_addr_unit.sv ***
/* self-checking bench for the addressing unit.
   assumes the execution model drives every design input except the clock and the reset, which the bench drives. */
`timescale 1ns/10ps

module test_pc_addr_unit;
    import pcstack_pkg::*;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    pc_cmd_s cmd;
    logic lwe, fwe, ibit;
    logic [HIGH_W-1:0] lwd, lat;
    logic [LOW_W-1:0] fwd, pc_low_byte_reg, fptr;
    logic [PC_W-1:0] pc;
    data_req_s dreq;
    data_acc_s acc;
    int fail_count = 0;
    int checks = 0;
    logic [PC_W-1:0] pushed [10];

    // 125 MHz clock
    always #4 clock_i = ~clock_i;

    exec_model model (.clock_i(clock_i), .pc_i(pc), .latch_i(lat), .pc_cmd_o(cmd),
        .latch_we_o(lwe), .latch_wdata_o(lwd), .fp_we_o(fwe), .fp_wdata_o(fwd),
        .bank_bit_o(ibit), .data_req_o(dreq));

    pc_addr_unit uut (.clock_i(clock_i), .nrst_i(nrst_i), .pc_cmd_i(cmd), .latch_we_i(lwe),
        .latch_wdata_i(lwd), .fp_we_i(fwe), .fp_wdata_i(fwd), .indirect_bank_bit_i(ibit),
        .data_req_i(dreq), .pc_o(pc), .pc_low_byte_reg_o(pc_low_byte_reg), .pc_high_latch_o(lat),
        .file_pointer_reg_o(fptr), .data_acc_o(acc));

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // counts and verdict
    task automatic print_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // low byte write and computed jumps
    task automatic t_low();
        model.latch(5'h1F);
        model.op(PC_WRITE_LOW, 8'hA5, '0, 1'b1);
        check(pc, 16'h1FA5);
        check(pc_low_byte_reg, 16'h00A5);
        model.latch(5'h02);
        model.op(PC_WRITE_LOW, 8'hF0, '0, 1'b1);
        check(pc, 16'h02F0);
        model.jump_table(8'h20);
        check(pc, 16'h0310);
        check(lat, 16'h0003);
        model.jump_table(8'h05);
        check(pc, 16'h0315);
        $display("low byte test done");
    endtask

    // goto over every page, call and interrupt with return
    task automatic t_jump();
        logic [HIGH_W-1:0] l [4] = '{5'h00, 5'h08, 5'h10, 5'h1F};
        for (int i = 0; i < 4; i++) begin
            model.latch(l[i]);
            model.op(PC_GOTO, '0, 11'h5A3, i < 3);
            check(pc, {3'b000, l[i][4:3], 11'h5A3});
        end
        model.op(PC_GOTO, '0, 11'h234, 1'b0);
        model.op(PC_CALL, '0, 11'h070, 1'b0);
        check(pc, 16'h1870);
        model.op(PC_RETURN, '0, '0, 1'b0);
        check(pc, 16'h1A34);
        check(lat, 16'h001F);
        model.op(PC_INTR, '0, '0, 1'b0);
        check(pc, {3'b000, INTR_VECTOR});
        model.op(PC_STEP, '0, '0, 1'b0);
        check(pc, 16'h0005);
        model.op(PC_RETURN, '0, '0, 1'b1);
        check(pc, 16'h1A34);
        $display("jump test done");
    endtask

    // ten calls wrap the eight slots, nine returns
    task automatic t_wrap();
        model.latch(5'h00);
        model.op(PC_GOTO, '0, '0, 1'b0);
        for (int k = 0; k < 10; k++) begin
            pushed[k] = (k == 0) ? 13'h0000 : 13'h0100 + 13'(k - 1);
            model.op(PC_CALL, '0, 11'h100 + 11'(k), 1'b0);
        end
        for (int k = 0; k < 9; k++) begin
            model.op(PC_RETURN, '0, '0, k == 8);
            check(pc, pushed[(k < 8) ? 9 - k : 9]);
        end
        $display("wrap test done");
    endtask

    // one data request and its resolved access
    task automatic acc_case(input logic w, input logic [1:0] b, input logic [6:0] a,
                            input logic ib, input data_acc_s e);
        model.req(w, b, a, ib);
        check(acc, e);
    endtask

    // indirect, self-selected and direct accesses
    task automatic t_ind();
        model.fp(8'h25);
        check(fptr, 16'h0025);
        acc_case(1'b0, 2'b00, 7'h00, 1'b1, {1'b1, 9'h125, 1'b0, 1'b0, 1'b1});
        acc_case(1'b1, 2'b01, 7'h00, 1'b0, {1'b1, 9'h025, 1'b1, 1'b0, 1'b1});
        model.fp(8'h80);
        acc_case(1'b0, 2'b00, 7'h00, 1'b1, {1'b1, 9'h180, 1'b0, 1'b1, 1'b1});
        acc_case(1'b1, 2'b00, 7'h00, 1'b0, {1'b1, 9'h080, 1'b0, 1'b0, 1'b1});
        acc_case(1'b1, 2'b10, 7'h15, 1'b1, {1'b1, 9'h115, 1'b1, 1'b0, 1'b0});
        model.idle();
        @(posedge clock_i);
        #1;
        check(acc.valid, 16'h0000);
        $display("indirect test done");
    endtask

    // reset in mid run clears counter and stack
    task automatic t_rst();
        model.op(PC_GOTO, '0, 11'h155, 1'b1);
        nrst_i = 1'b0;
        #1;
        check(pc, 16'h0000);
        @(posedge clock_i);
        #1;
        nrst_i = 1'b1;
        model.op(PC_RETURN, '0, '0, 1'b1);
        check(pc, 16'h0000);
        $display("reset test done");
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        print_verdict();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clock_i);
        #1;
        nrst_i = 1'b1;
        check(pc, 16'h0000);
        check(fptr, 16'h0000);
        t_low();
        t_jump();
        t_wrap();
        t_ind();
        t_rst();
        print_verdict();
    end
endmodule
